// ### design/pio_regs_pkg.sv
// Package for the parallel I/O controller register block: offsets, reset values, field layout.
// Assumes a 32-bit APB slave with byte addresses; one register per aligned word.
package pio_regs_pkg;
   localparam logic [7:0] OFF_OWN_EN = 8'h00;
   localparam logic [7:0] OFF_OWN_DIS = 8'h04;
   localparam logic [7:0] OFF_OWN_ST = 8'h08;
   localparam logic [7:0] OFF_DRV_EN = 8'h10;
   localparam logic [7:0] OFF_DRV_DIS = 8'h14;
   localparam logic [7:0] OFF_DRV_ST = 8'h18;
   localparam logic [7:0] OFF_FLT_EN = 8'h20;
   localparam logic [7:0] OFF_FLT_DIS = 8'h24;
   localparam logic [7:0] OFF_FLT_ST = 8'h28;
   localparam logic [7:0] OFF_OUT_SET = 8'h30;
   localparam logic [7:0] OFF_OUT_CLR = 8'h34;
   localparam logic [7:0] OFF_OUT_ST = 8'h38;
   localparam logic [7:0] OFF_PIN = 8'h3c;
   localparam logic [7:0] OFF_IRQ_EN = 8'h40;
   localparam logic [7:0] OFF_IRQ_DIS = 8'h44;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h4c;
   localparam logic [7:0] OFF_OD_EN = 8'h50;
   localparam logic [7:0] OFF_OD_DIS = 8'h54;
   localparam logic [7:0] OFF_OD_ST = 8'h58;
   localparam logic [7:0] OFF_PU_DIS = 8'h60;
   localparam logic [7:0] OFF_PU_EN = 8'h64;
   localparam logic [7:0] OFF_PU_ST = 8'h68;
   localparam logic [7:0] OFF_SEL_FIRST = 8'h70;
   localparam logic [7:0] OFF_SEL_SECOND = 8'h74;
   localparam logic [7:0] OFF_SEL_ST = 8'h78;
   localparam logic [7:0] OFF_DW_EN = 8'ha0;
   localparam logic [7:0] OFF_DW_DIS = 8'ha4;
   localparam logic [7:0] OFF_DW_ST = 8'ha8;
   localparam logic [7:0] OFF_DELAY0 = 8'hc0;
   localparam logic [7:0] OFF_DELAY3 = 8'hcc;
   localparam logic [7:0] OFF_PROT_MODE = 8'he4;
   localparam logic [7:0] OFF_PROT_ST = 8'he8;

   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [3:0] DELAY_NONE = 4'h0;
   localparam logic [3:0] DELAY_MAX = 4'hf;
   localparam int DELAY_FIELD_W = 4;
   localparam int DELAY_MAX_PS = 4000;
   localparam int DELAY_STEPS = 16;
   localparam int DELAY_STEP_PS = DELAY_MAX_PS / DELAY_STEPS;

   // Protection mode: enable at bit 0
   localparam int PROT_EN_BIT = 0;
   // Protection status: violation flag at bit 0, source offset at bits 15:8
   localparam int PROT_FLAG_BIT = 0;
   localparam int PROT_SRC_LSB = 8;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage : pio_regs_pkg

// ### design/pio_regs.sv
// Register block of a 32-line parallel I/O controller with write protection and pad delays.
// Assumes an APB master on sys_clk_i; pin levels and change events arrive synchronous to it.
//
// Contract
// RQ1 - Protection enable set rejects writes to all listed configuration registers
// RQ2 - A rejected write sets violation flag and records the targeted register
// RQ3 - Reading protection status clears the violation flag
// RQ4 - Sixteen write-only set/clear registers form the protected set
// RQ5 - Each delay-capable pad gets its own programmable output delay
// RQ6 - Delay fields are 4 bits; 0 adds nothing, 0xF gives about 4 ns
// RQ7 - Smallest nonzero delay step is one sixteenth of the maximum
// RQ8 - Only listed A and C pads carry delay fields
// RQ9 - All registers 32 bits; bit n maps to line n
// RQ10 - Unimplemented line bits ignore writes and read zero
// RQ11 - Lines without a peripheral stay owned by the controller, status reads 1
// RQ12 - Output level status is written directly only on mask-enabled bits
// RQ13 - Pin level register holds sampled levels; frozen while clock gated
// RQ14 - Change flags reset to zero; first read may show changes
// RQ15 - First select write clears selection bit, second select write sets it
// RQ16 - Pull-up enable/disable set and clear status, reset zero
// RQ17 - Enable writes set status, disable writes clear it, zeros ignored
// RQ18 - Reading change flags clears all pending flags at once
// RQ19 - Ownership bit 1 means controller drives the line, 0 peripheral
// RQ20 - Rejected writes change nothing; source field holds targeted offset
// RQ21 - Reserved offsets ignore writes and read zero
`timescale 1ns/10ps
module pio_regs #(
   parameter logic [31:0] LINE_MASK = 32'hffff_ffff,
   parameter logic [31:0] PERIPH_MASK = 32'hffff_ffff,
   parameter logic [31:0] DELAY_MASK = 32'h7f80_03fc
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [31:0] pin_level_i,
   input wire logic pclk_on_i,
   input wire logic [31:0] change_i,
   output logic [31:0] owned_o,
   output logic [31:0] drive_o,
   output logic [31:0] filter_o,
   output logic [31:0] level_o,
   output logic [31:0] irq_mask_o,
   output logic [31:0] open_drain_o,
   output logic [31:0] pullup_o,
   output logic [31:0] periph_sel_o,
   output logic [127:0] pad_delay_o
);
   // Refuse delay fields on lines that do not exist
   if ((DELAY_MASK & ~LINE_MASK) != 32'h0000_0000) begin : g_bad_mask
      $error("Delay pads must be implemented lines");
   end

   pio_regs_pkg::apb_req_t req;
   assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};

   logic wr;
   logic rd;
   logic prot_en_ff;
   logic prot_hit;
   logic wr_ok;
   logic [31:0] wd;
   assign wr = req.psel & req.penable & req.pwrite;
   assign rd = req.psel & req.penable & ~req.pwrite;
   assign wd = req.pwdata & LINE_MASK; // RQ10

   // Membership in the protected set of sixteen set/clear registers
   function automatic logic is_protected(input logic [7:0] a);
      unique case (a)
         pio_regs_pkg::OFF_OWN_EN, pio_regs_pkg::OFF_OWN_DIS,
         pio_regs_pkg::OFF_DRV_EN, pio_regs_pkg::OFF_DRV_DIS,
         pio_regs_pkg::OFF_FLT_EN, pio_regs_pkg::OFF_FLT_DIS,
         pio_regs_pkg::OFF_OUT_SET, pio_regs_pkg::OFF_OUT_CLR,
         pio_regs_pkg::OFF_OD_EN, pio_regs_pkg::OFF_OD_DIS,
         pio_regs_pkg::OFF_PU_DIS, pio_regs_pkg::OFF_PU_EN,
         pio_regs_pkg::OFF_SEL_FIRST, pio_regs_pkg::OFF_SEL_SECOND,
         pio_regs_pkg::OFF_DW_EN, pio_regs_pkg::OFF_DW_DIS: is_protected = 1'b1; // RQ4
         default: is_protected = 1'b0;
      endcase
   endfunction : is_protected

   function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] s,
                                           input logic [31:0] c);
      set_clr = (cur | s) & ~c;
   endfunction : set_clr

   assign prot_hit = wr & prot_en_ff & is_protected(req.paddr); // RQ1
   assign wr_ok = wr & ~prot_hit; // RQ20

   // Write strobes per address
   function automatic logic [31:0] wsel(input logic ok, input logic [7:0] a,
                                        input logic [7:0] t, input logic [31:0] d);
      wsel = (ok && a == t) ? d : 32'h0000_0000;
   endfunction : wsel

   logic [31:0] own_ff;
   logic [31:0] drv_ff;
   logic [31:0] flt_ff;
   logic [31:0] lvl_ff;
   logic [31:0] imr_ff;
   logic [31:0] isr_ff;
   logic [31:0] od_ff;
   logic [31:0] pu_ff;
   logic [31:0] sel_ff;
   logic [31:0] dw_ff;
   logic [31:0] pin_ff;
   logic [31:0] dly_ff [4];
   logic viol_ff;
   logic [7:0] vsrc_ff;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         own_ff <= 32'hffff_ffff & LINE_MASK;
      end else begin
         // Lines with no peripheral stay owned by the controller
         own_ff <= (set_clr(own_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OWN_EN, wd),
                    wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OWN_DIS, wd))
                    | ~PERIPH_MASK) & LINE_MASK; // RQ11 RQ17 RQ19
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         drv_ff <= pio_regs_pkg::RST_ZERO;
         flt_ff <= pio_regs_pkg::RST_ZERO;
         imr_ff <= pio_regs_pkg::RST_ZERO;
         od_ff <= pio_regs_pkg::RST_ZERO;
         pu_ff <= pio_regs_pkg::RST_ZERO;
         dw_ff <= pio_regs_pkg::RST_ZERO;
         sel_ff <= pio_regs_pkg::RST_ZERO;
      end else begin
         drv_ff <= set_clr(drv_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_DRV_EN, wd),
                   wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_DRV_DIS, wd)); // RQ17
         flt_ff <= set_clr(flt_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_FLT_EN, wd),
                   wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_FLT_DIS, wd)); // RQ17
         imr_ff <= set_clr(imr_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_IRQ_EN, wd),
                   wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_IRQ_DIS, wd)); // RQ17
         od_ff <= set_clr(od_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OD_EN, wd),
                  wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OD_DIS, wd)); // RQ17
         pu_ff <= set_clr(pu_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_PU_EN, wd),
                  wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_PU_DIS, wd)); // RQ16
         dw_ff <= set_clr(dw_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_DW_EN, wd),
                  wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_DW_DIS, wd)); // RQ17
         sel_ff <= set_clr(sel_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_SEL_SECOND, wd),
                   wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_SEL_FIRST, wd)); // RQ15
      end
   end

   // Output level: set/clear pair plus masked direct write
   logic [31:0] dir_wr;
   assign dir_wr = wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OUT_ST, 32'hffff_ffff) & dw_ff;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         lvl_ff <= pio_regs_pkg::RST_ZERO;
      end else begin
         lvl_ff <= (set_clr(lvl_ff, wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OUT_SET, wd),
                    wsel(wr_ok, req.paddr, pio_regs_pkg::OFF_OUT_CLR, wd))
                    & ~dir_wr) | (wd & dir_wr); // RQ12
      end
   end

   // Pin sampling frozen while the controller clock is gated off
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pin_ff <= pio_regs_pkg::RST_ZERO;
      end else if (pclk_on_i) begin
         pin_ff <= pin_level_i & LINE_MASK; // RQ13
      end
   end

   // Change flags: new events win over the read clear
   logic isr_rd;
   assign isr_rd = rd && req.paddr == pio_regs_pkg::OFF_IRQ_FLAGS;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         isr_ff <= pio_regs_pkg::RST_ZERO; // RQ14
      end else begin
         isr_ff <= ((isr_rd ? 32'h0000_0000 : isr_ff) | change_i) & LINE_MASK; // RQ18
      end
   end

   // Pad delays: eight fields of four bits per register, only capable pads kept
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_dly
         logic [31:0] fmask;
         for (genvar f = 0; f < 8; f++) begin : g_f
            assign fmask[f*4 +: 4] = {4{DELAY_MASK[g*8+f]}}; // RQ8
         end
         always_ff @(posedge sys_clk_i) begin
            if (reset_i) begin
               dly_ff[g] <= pio_regs_pkg::RST_ZERO; // RQ6
            end else if (wr && req.paddr == pio_regs_pkg::OFF_DELAY0 + 8'(g * 4)) begin
               dly_ff[g] <= req.pwdata & fmask; // RQ5
            end
         end
         // Each code step is DELAY_STEP_PS; the pad applies code times that step
         assign pad_delay_o[g*32 +: 32] = dly_ff[g]; // RQ7
      end
   endgenerate

   // Protection mode and violation status
   logic prot_rd;
   assign prot_rd = rd && req.paddr == pio_regs_pkg::OFF_PROT_ST;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prot_en_ff <= 1'b0;
      end else if (wr && req.paddr == pio_regs_pkg::OFF_PROT_MODE) begin
         prot_en_ff <= req.pwdata[pio_regs_pkg::PROT_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         viol_ff <= 1'b0;
         vsrc_ff <= 8'h00;
      end else if (prot_hit) begin
         viol_ff <= 1'b1; // RQ2
         vsrc_ff <= req.paddr; // RQ20
      end else if (prot_rd) begin
         viol_ff <= 1'b0; // RQ3
      end
   end

   // Read mux; unmapped offsets read zero
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h0000_0000; // RQ21
      unique case (req.paddr)
         pio_regs_pkg::OFF_OWN_ST: nxt_rdata = own_ff;
         pio_regs_pkg::OFF_DRV_ST: nxt_rdata = drv_ff;
         pio_regs_pkg::OFF_FLT_ST: nxt_rdata = flt_ff;
         pio_regs_pkg::OFF_OUT_ST: nxt_rdata = lvl_ff;
         pio_regs_pkg::OFF_PIN: nxt_rdata = pin_ff;
         pio_regs_pkg::OFF_IRQ_MASK: nxt_rdata = imr_ff;
         pio_regs_pkg::OFF_IRQ_FLAGS: nxt_rdata = isr_ff;
         pio_regs_pkg::OFF_OD_ST: nxt_rdata = od_ff;
         pio_regs_pkg::OFF_PU_ST: nxt_rdata = pu_ff;
         pio_regs_pkg::OFF_SEL_ST: nxt_rdata = sel_ff;
         pio_regs_pkg::OFF_DW_ST: nxt_rdata = dw_ff;
         8'hc0: nxt_rdata = dly_ff[0];
         8'hc4: nxt_rdata = dly_ff[1];
         8'hc8: nxt_rdata = dly_ff[2];
         pio_regs_pkg::OFF_DELAY3: nxt_rdata = dly_ff[3];
         pio_regs_pkg::OFF_PROT_MODE: nxt_rdata = {31'h0, prot_en_ff};
         pio_regs_pkg::OFF_PROT_ST: nxt_rdata = {16'h0000, vsrc_ff, 7'h00, viol_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end
   assign prdata_o = (req.psel & ~req.pwrite) ? nxt_rdata : 32'h0000_0000; // RQ9
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;

   assign owned_o = own_ff;
   assign drive_o = drv_ff;
   assign filter_o = flt_ff;
   assign level_o = lvl_ff;
   assign irq_mask_o = imr_ff;
   assign open_drain_o = od_ff;
   assign pullup_o = pu_ff;
   assign periph_sel_o = sel_ff;

   // Checks
   a_prot_blocks: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ1
      prot_en_ff && wr && req.paddr == pio_regs_pkg::OFF_DRV_EN |=> $stable(drv_ff))
      else $error("protected write changed drive state");
   a_prot_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ2
      prot_hit |=> viol_ff && vsrc_ff == $past(req.paddr))
      else $error("violation not recorded");
   a_prot_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ3
      prot_rd && !prot_hit |=> !viol_ff)
      else $error("violation flag not cleared by read");
   a_reject_stable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ1 RQ20
      prot_hit |=> $stable(own_ff) && $stable(drv_ff) && $stable(flt_ff) && $stable(lvl_ff)
      && $stable(od_ff) && $stable(pu_ff) && $stable(sel_ff) && $stable(dw_ff))
      else $error("rejected write changed state");

   // Set/clear pairs and masked direct write
   a_set_enable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_OD_EN |=> (od_ff & $past(wd)) == $past(wd))
      else $error("enable write did not set status");
   a_od_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_OD_DIS |=>
      (od_ff & $past(wd)) == 32'h0)
      else $error("disable write did not clear open drain");
   a_drv_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_DRV_DIS |=>
      (drv_ff & $past(wd)) == 32'h0)
      else $error("disable write did not clear drive");
   a_flt_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_FLT_DIS |=>
      (flt_ff & $past(wd)) == 32'h0)
      else $error("disable write did not clear filter");
   a_irq_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_IRQ_DIS |=>
      (imr_ff & $past(wd)) == 32'h0)
      else $error("disable write did not clear mask");
   a_dw_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_DW_DIS |=>
      (dw_ff & $past(wd)) == 32'h0)
      else $error("disable write did not clear write mask");
   a_out_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ17
      wr_ok && req.paddr == pio_regs_pkg::OFF_OUT_CLR |=>
      (lvl_ff & $past(wd)) == 32'h0)
      else $error("clear write did not clear level");
   a_pu_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ16
      wr_ok && req.paddr == pio_regs_pkg::OFF_PU_DIS |=>
      (pu_ff & $past(wd)) == 32'h0)
      else $error("disable write did not clear pull-up");
   a_sel_first: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ15
      wr_ok && req.paddr == pio_regs_pkg::OFF_SEL_FIRST |=>
      (sel_ff & $past(wd)) == 32'h0)
      else $error("first select did not clear status");
   a_sel_second: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ15
      wr_ok && req.paddr == pio_regs_pkg::OFF_SEL_SECOND |=>
      (sel_ff & $past(wd)) == $past(wd))
      else $error("second select did not set status");
   a_own_release: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ19
      wr_ok && req.paddr == pio_regs_pkg::OFF_OWN_DIS |=>
      (own_ff & $past(wd) & PERIPH_MASK) == 32'h0)
      else $error("ownership not handed to peripheral");
   a_direct_mask: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ12
      wr_ok && req.paddr == pio_regs_pkg::OFF_OUT_ST |=>
      ((lvl_ff ^ $past(lvl_ff)) & ~$past(dw_ff)) == 32'h0000_0000)
      else $error("direct write touched masked bit");

   // Inputs, reset values and read side
   a_isr_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ18
      isr_rd |=> isr_ff == ($past(change_i) & LINE_MASK))
      else $error("change flags not cleared on read");
   a_pin_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ13
      !pclk_on_i [*2] |-> $stable(pin_ff))
      else $error("pin level moved with clock off");
   a_pin_follow: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ13
      pclk_on_i |=> pin_ff == ($past(pin_level_i) & LINE_MASK))
      else $error("pin level not sampled");
   a_own_fixed: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ11
      ((~own_ff) & ~PERIPH_MASK & LINE_MASK) == 32'h0000_0000)
      else $error("line without peripheral lost ownership");
   a_unused_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ10
      ((own_ff | drv_ff | flt_ff | lvl_ff | imr_ff | isr_ff | od_ff | pu_ff | sel_ff | dw_ff
      | pin_ff) & ~LINE_MASK) == 32'h0)
      else $error("unimplemented line bit set");
   a_reset_zero: assert property (@(posedge sys_clk_i) // RQ14 RQ16 RQ6
      reset_i |=> isr_ff == 32'h0 && pu_ff == 32'h0 && dly_ff[0] == 32'h0
      && dly_ff[3] == 32'h0 && own_ff == LINE_MASK)
      else $error("register not at reset value");
   a_reserved_read: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ21
      rd && req.paddr > pio_regs_pkg::OFF_SEL_ST && req.paddr < pio_regs_pkg::OFF_DW_EN |->
      prdata_o == 32'h0)
      else $error("reserved offset read nonzero");
   a_delay_write: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ5 RQ8
      wr && req.paddr == pio_regs_pkg::OFF_DELAY0 |=>
      dly_ff[0] == ($past(req.pwdata) & g_dly[0].fmask))
      else $error("delay write not applied");
   a_delay_pads: assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ8
      ##1 (dly_ff[0][3:0] == pio_regs_pkg::DELAY_NONE || DELAY_MASK[0]))
      else $error("delay on incapable pad");

   c_violation: cover property (@(posedge sys_clk_i) disable iff (reset_i) prot_hit);
   c_direct: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_ok && req.paddr == pio_regs_pkg::OFF_OUT_ST && dw_ff != 32'h0000_0000);
   c_isr_read: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      isr_rd && isr_ff != 32'h0000_0000);
   c_delay_max: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      dly_ff[3][27:24] == pio_regs_pkg::DELAY_MAX);
   c_own_release: cover property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_ok && req.paddr == pio_regs_pkg::OFF_OWN_DIS);
endmodule : pio_regs

// ### verification/tb_top.sv
// Self-checking bench for the parallel I/O register block, driven over APB.
// Assumes the design answers with pready high and samples pins on sys_clk_i.
`timescale 1ns/10ps
module tb_top;
   localparam logic [31:0] LM = 32'h7fff_ffff;
   localparam logic [31:0] PM = 32'h0fff_ffff;
   localparam logic [31:0] DM = 32'h7f80_03fc;
   localparam logic [31:0] PAT = 32'ha5a5_f00f;
   localparam logic [31:0] DIS = 32'h0f0f_00ff;
   // Offsets whose reset value is zero, reserved places included
   localparam logic [143:0] ZOFF = {pio_regs_pkg::OFF_DRV_ST, pio_regs_pkg::OFF_FLT_ST,
      pio_regs_pkg::OFF_IRQ_MASK, pio_regs_pkg::OFF_IRQ_FLAGS, pio_regs_pkg::OFF_OD_ST,
      pio_regs_pkg::OFF_PU_ST, pio_regs_pkg::OFF_SEL_ST, pio_regs_pkg::OFF_DW_ST,
      pio_regs_pkg::OFF_DELAY0, 8'hc4, 8'hc8, pio_regs_pkg::OFF_DELAY3,
      pio_regs_pkg::OFF_PROT_MODE, pio_regs_pkg::OFF_PROT_ST, 8'h0c, 8'h7c, 8'hf0, 8'hac};
   logic sys_clk_i, reset_i, psel, pen, pwr, pclk_on, pready, pslverr;
   logic [7:0] paddr, st, a;
   logic [15:0] p;
   logic [31:0] pwdata, pin, chg, q, frc, prdata;
   logic [31:0] owned, drive, filter, level, irqm, od, pu, sel;
   logic [127:0] dly;
   logic [31:0] shadow [9];
   int fails, checked;

   pio_regs #(.LINE_MASK(LM), .PERIPH_MASK(PM), .DELAY_MASK(DM)) DUT (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pin_level_i(pin), .pclk_on_i(pclk_on),
      .change_i(chg), .owned_o(owned), .drive_o(drive), .filter_o(filter), .level_o(level),
      .irq_mask_o(irqm), .open_drain_o(od), .pullup_o(pu), .periph_sel_o(sel),
      .pad_delay_o(dly));

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
         fails++;
      end
   endtask : check

   // One APB transfer; read data is taken at the edge that sees pready high
   task automatic apb(input logic wr_en, input logic [7:0] adr, input logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr_en;
      paddr <= adr;
      pwdata <= d;
      @(posedge sys_clk_i);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         summarize();
      end
      q = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      apb(1'b1, adr, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      apb(1'b0, adr, 32'h0);
      check(q, exp);
   endtask : rd_chk

   // Set and clear offsets of each pair; the status sits at offset 8 of its group
   function automatic logic [15:0] pr(input int i);
      case (i)
         0: return {pio_regs_pkg::OFF_OWN_EN, pio_regs_pkg::OFF_OWN_DIS};
         1: return {pio_regs_pkg::OFF_DRV_EN, pio_regs_pkg::OFF_DRV_DIS};
         2: return {pio_regs_pkg::OFF_FLT_EN, pio_regs_pkg::OFF_FLT_DIS};
         3: return {pio_regs_pkg::OFF_OUT_SET, pio_regs_pkg::OFF_OUT_CLR};
         4: return {pio_regs_pkg::OFF_IRQ_EN, pio_regs_pkg::OFF_IRQ_DIS};
         5: return {pio_regs_pkg::OFF_OD_EN, pio_regs_pkg::OFF_OD_DIS};
         6: return {pio_regs_pkg::OFF_PU_EN, pio_regs_pkg::OFF_PU_DIS};
         7: return {pio_regs_pkg::OFF_SEL_SECOND, pio_regs_pkg::OFF_SEL_FIRST};
         default: return {pio_regs_pkg::OFF_DW_EN, pio_regs_pkg::OFF_DW_DIS};
      endcase
   endfunction : pr

   function automatic logic [31:0] port(input int i);
      case (i)
         0: return owned;
         1: return drive;
         2: return filter;
         3: return level;
         4: return irqm;
         5: return od;
         6: return pu;
         default: return sel;
      endcase
   endfunction : port

   function automatic logic [31:0] dexp(input int g);
      logic [31:0] r;
      r = '0;
      for (int f = 0; f < 8; f++) begin
         if (DM[8 * g + f]) begin
            r[4 * f +: 4] = 4'hf;
         end
      end
      return r;
   endfunction : dexp

   initial begin
      fails = 0;
      checked = 0;
      reset_i <= 1'b1;
      {psel, pen, pwr, paddr, pwdata} <= '0;
      pin <= 32'h0;
      chg <= 32'h0;
      pclk_on <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      rd_chk(pio_regs_pkg::OFF_OWN_ST, LM);
      for (int i = 0; i < 18; i++) begin
         rd_chk(ZOFF[8 * i +: 8], 32'h0);
      end
      $display("test reset_values done");
      for (int i = 0; i < 9; i++) begin
         p = pr(i);
         st = (p[15:8] & 8'hf0) | 8'h08;
         frc = (i == 0) ? ~PM : 32'h0;
         wr(p[7:0], 32'hffff_ffff);
         wr(p[15:8], PAT);
         rd_chk(st, (PAT | frc) & LM);
         wr(p[15:8], 32'h0);
         wr(p[7:0], 32'h0);
         rd_chk(st, (PAT | frc) & LM);
         wr(p[7:0], DIS);
         shadow[i] = ((PAT & ~DIS) | frc) & LM;
         rd_chk(st, shadow[i]);
         if (i < 8) begin
            check(port(i), shadow[i]);
         end
      end
      $display("test set_clear_pairs done");
      wr(pio_regs_pkg::OFF_DW_DIS, 32'hffff_ffff);
      wr(pio_regs_pkg::OFF_DW_EN, 32'h0000_00ff);
      wr(pio_regs_pkg::OFF_OUT_CLR, 32'hffff_ffff);
      wr(pio_regs_pkg::OFF_OUT_ST, 32'hffff_ffff);
      rd_chk(pio_regs_pkg::OFF_OUT_ST, 32'h0000_00ff);
      check(level, 32'h0000_00ff);
      shadow[3] = 32'h0000_00ff;
      shadow[8] = 32'h0000_00ff;
      $display("test direct_write done");
      pin <= 32'h9234_5678;
      repeat (3) @(posedge sys_clk_i);
      rd_chk(pio_regs_pkg::OFF_PIN, 32'h1234_5678);
      pclk_on <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      pin <= 32'h0000_ffff;
      repeat (3) @(posedge sys_clk_i);
      rd_chk(pio_regs_pkg::OFF_PIN, 32'h1234_5678);
      pclk_on <= 1'b1;
      chg <= 32'h8000_0f00;
      @(posedge sys_clk_i);
      chg <= 32'h0;
      rd_chk(pio_regs_pkg::OFF_IRQ_FLAGS, 32'h0000_0f00);
      rd_chk(pio_regs_pkg::OFF_IRQ_FLAGS, 32'h0);
      $display("test pins_and_changes done");
      wr(pio_regs_pkg::OFF_PROT_MODE, 32'h1);
      rd_chk(pio_regs_pkg::OFF_PROT_MODE, 32'h1);
      for (int i = 0; i < 9; i++) begin
         p = pr(i);
         st = (p[15:8] & 8'hf0) | 8'h08;
         for (int k = 0; k < 2 && i != 4; k++) begin
            a = (k == 0) ? p[15:8] : p[7:0];
            wr(a, 32'h5a5a_5a5a);
            rd_chk(st, shadow[i]);
            rd_chk(pio_regs_pkg::OFF_PROT_ST, {16'h0, a, 8'h01});
            apb(1'b0, pio_regs_pkg::OFF_PROT_ST, 32'h0);
            check({31'h0, q[0]}, 32'h0);
         end
      end
      wr(pio_regs_pkg::OFF_IRQ_EN, 32'hffff_ffff);
      rd_chk(pio_regs_pkg::OFF_IRQ_MASK, LM);
      wr(pio_regs_pkg::OFF_PROT_MODE, 32'h0);
      wr(pio_regs_pkg::OFF_DRV_EN, 32'hffff_ffff);
      rd_chk(pio_regs_pkg::OFF_DRV_ST, LM);
      check({31'h0, pslverr}, 32'h0);
      $display("test protection done");
      for (int g = 0; g < 4; g++) begin
         wr(pio_regs_pkg::OFF_DELAY0 + 8'(4 * g), 32'hffff_ffff);
         rd_chk(pio_regs_pkg::OFF_DELAY0 + 8'(4 * g), dexp(g));
         check(dly[32 * g +: 32], dexp(g));
      end
      wr(pio_regs_pkg::OFF_DELAY0, 32'h0);
      rd_chk(pio_regs_pkg::OFF_DELAY0, 32'h0);
      wr(8'h7c, 32'hffff_ffff);
      rd_chk(8'h7c, 32'h0);
      $display("test delays_reserved done");
      summarize();
   end
endmodule : tb_top
